// File: hdl/odd_top.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module odd_top
  import odd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [odd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic alarm,
  input wire logic crystal_ref_loss,
  input wire logic [odd_pkg::N_LOOP-1:0] loop_unlocked,
  output logic [odd_pkg::N_OUT-1:0] drv_active,
  output logic [odd_pkg::N_OUT-1:0] drv_hold_high
);
  import odd_pkg::*;

  // Fault synchronisers
  logic [N_LOOP+1:0] sync1_reg;
  logic [N_LOOP+1:0] sync2_reg;
  logic [N_LOOP+1:0] sync1_next;
  logic [N_LOOP+1:0] sync2_next;

  always_comb begin
    sync1_next = {alarm, crystal_ref_loss, loop_unlocked};
    sync2_next = sync1_reg;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  logic alarm_s;
  logic ref_loss_s;
  logic [N_LOOP-1:0] unlocked_s;
  assign alarm_s = sync2_reg[N_LOOP+1];
  assign ref_loss_s = sync2_reg[N_LOOP];
  assign unlocked_s = sync2_reg[N_LOOP-1:0];

  // Register file
  logic [7:0] cfg_reg [N_CFG];
  logic [7:0] cfg_next [N_CFG];
  logic [FORCE_LO_W-1:0] force_lo_reg;
  logic [FORCE_LO_W-1:0] force_lo_next;
  logic [FORCE_HI_W-1:0] force_hi_reg;
  logic [FORCE_HI_W-1:0] force_hi_next;
  logic [7:0] alarm_msk_reg;
  logic [7:0] alarm_msk_next;
  logic [N_LOOP-1:0] lock_msk_reg;
  logic [N_LOOP-1:0] lock_msk_next;

  logic [IDX_W-1:0] idx;
  logic [IDX_W-1:0] cfg_off;
  logic in_cfg;
  logic hit;
  logic wr_en;
  assign idx = paddr[ADDR_W-1:2];
  assign cfg_off = idx - IDX_CFG_BASE;
  // Groups sit back to back, the last aux group ends the range
  assign in_cfg = (idx >= IDX_CFG_BASE) && (idx <= IDX_CFG_LAST);
  assign hit = (paddr[1:0] == 2'h0) &&
               (in_cfg || idx == IDX_FORCE_LO || idx == IDX_FORCE_HI ||
                idx == IDX_ALARM_MSK || idx == IDX_LOCK_MSK ||
                idx == IDX_STATUS);
  // Only the low byte lane carries register data
  assign wr_en = psel & penable & pwrite & hit & pstrb[0];

  always_comb begin
    for (int i = 0; i < N_CFG; i++) begin
      cfg_next[i] = cfg_reg[i];
    end
    force_lo_next = force_lo_reg;
    force_hi_next = force_hi_reg;
    alarm_msk_next = alarm_msk_reg;
    lock_msk_next = lock_msk_reg;
    if (wr_en) begin
      if (in_cfg) begin
        cfg_next[cfg_off[5:0]] = pwdata[7:0];
      end
      if (idx == IDX_FORCE_LO) begin
        force_lo_next = pwdata[FORCE_LO_W-1:0];
      end
      if (idx == IDX_FORCE_HI) begin
        force_hi_next = pwdata[FORCE_HI_W-1:0];
      end
      if (idx == IDX_ALARM_MSK) begin
        alarm_msk_next = 8'h00;
        alarm_msk_next[ALARM_MSK_BIT] = pwdata[ALARM_MSK_BIT];
        alarm_msk_next[REF_LOSS_MSK_BIT] = pwdata[REF_LOSS_MSK_BIT];
      end
      if (idx == IDX_LOCK_MSK) begin
        lock_msk_next = pwdata[N_LOOP-1:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < N_CFG; i++) begin
        cfg_reg[i] <= CFG_RESET;
      end
      force_lo_reg <= FORCE_LO_RESET;
      force_hi_reg <= FORCE_HI_RESET;
      alarm_msk_reg <= ALARM_MSK_RESET;
      lock_msk_reg <= LOCK_MSK_RESET;
    end else begin
      for (int i = 0; i < N_CFG; i++) begin
        cfg_reg[i] <= cfg_next[i];
      end
      force_lo_reg <= force_lo_next;
      force_hi_reg <= force_hi_next;
      alarm_msk_reg <= alarm_msk_next;
      lock_msk_reg <= lock_msk_next;
    end
  end

  // Per-output fields and the shared fault decision
  logic [N_OUT-1:0] force_vec;
  logic [N_OUT-1:0] oe_vec;
  logic [N_OUT-1:0] pdn_vec;
  logic [1:0] level_vec [N_OUT];
  logic fault_any;

  // Bit order gives aux0, out0..out9, aux9 as one ascending vector
  assign force_vec = {force_hi_reg, force_lo_reg};

  always_comb begin
    for (int i = 0; i < N_OUT; i++) begin
      oe_vec[i] = cfg_reg[i*REGS_PER_OUT + GRP_CTRL][CTRL_OE_BIT];
      pdn_vec[i] = cfg_reg[i*REGS_PER_OUT + GRP_CTRL][CTRL_PDN_BIT];
      level_vec[i] =
        cfg_reg[i*REGS_PER_OUT + GRP_FORMAT][DIS_LEVEL_LSB +: 2];
    end
  end

  always_comb begin
    fault_any = (alarm_s & ~alarm_msk_reg[ALARM_MSK_BIT]) |
                (ref_loss_s & ~alarm_msk_reg[REF_LOSS_MSK_BIT]) |
                (|(unlocked_s & ~lock_msk_reg));
  end

  for (genvar g = 0; g < N_OUT; g++) begin : g_drv
    odd_drv_ctl u_drv (
      .mclk(mclk),
      .rst_b(rst_b),
      .out_enable(oe_vec[g]),
      .power_down(pdn_vec[g]),
      .force_active(force_vec[g]),
      .fault(fault_any),
      .dis_level(level_vec[g]),
      .drv_active(drv_active[g]),
      .drv_hold_high(drv_hold_high[g])
    );
  end

  // Read path: data is captured in the setup cycle so the access phase
  // completes at once with a stable registered answer
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic err_reg;
  logic err_next;
  logic [31:0] rd_val;

  always_comb begin
    rd_val = 32'h0000_0000;
    if (in_cfg) begin
      rd_val[7:0] = cfg_reg[cfg_off[5:0]];
    end else if (idx == IDX_FORCE_LO) begin
      rd_val[FORCE_LO_W-1:0] = force_lo_reg;
    end else if (idx == IDX_FORCE_HI) begin
      rd_val[FORCE_HI_W-1:0] = force_hi_reg;
    end else if (idx == IDX_ALARM_MSK) begin
      rd_val[7:0] = alarm_msk_reg;
    end else if (idx == IDX_LOCK_MSK) begin
      rd_val[N_LOOP-1:0] = lock_msk_reg;
    end else if (idx == IDX_STATUS) begin
      rd_val[N_OUT-1:0] = drv_active;
      rd_val[STAT_SYNC_LSB +: N_LOOP+2] = sync2_reg;
      rd_val[STAT_FAULT_BIT] = fault_any;
    end
  end

  always_comb begin
    rdata_next = rdata_reg;
    err_next = err_reg;
    if (psel && !penable) begin
      rdata_next = (hit && !pwrite) ? rd_val : 32'h0000_0000;
      err_next = ~hit;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= 32'h0000_0000;
      err_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      err_reg <= err_next;
    end
  end

  assign prdata = rdata_reg;
  assign pready = 1'b1;
  assign pslverr = psel & penable & err_reg;
endmodule
`default_nettype wire

// File: hdl/odd_pkg.sv
package odd_pkg;
  // Outputs in order: first aux, outputs 0 to 9, last aux
  localparam int N_OUT = 12;
  localparam int N_LOOP = 4;
  localparam int REGS_PER_OUT = 5;
  localparam int N_CFG = N_OUT * REGS_PER_OUT;
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CFG_BASE = 10'h103;
  localparam logic [IDX_W-1:0] IDX_CFG_LAST = 10'h13E;
  localparam logic [IDX_W-1:0] IDX_FORCE_LO = 10'h13F;
  localparam logic [IDX_W-1:0] IDX_FORCE_HI = 10'h140;
  localparam logic [IDX_W-1:0] IDX_ALARM_MSK = 10'h141;
  localparam logic [IDX_W-1:0] IDX_LOCK_MSK = 10'h142;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h150;
  // Register positions inside one output group
  localparam int GRP_CTRL = 0;
  localparam int GRP_FORMAT = 1;
  localparam int GRP_DIS_SRC = 4;
  // Field positions
  localparam int CTRL_PDN_BIT = 0;
  localparam int CTRL_OE_BIT = 1;
  localparam int DIS_LEVEL_LSB = 4;
  localparam int ALARM_MSK_BIT = 1;
  localparam int REF_LOSS_MSK_BIT = 6;
  localparam int FORCE_LO_W = 8;
  localparam int FORCE_HI_W = 4;
  localparam int STAT_FAULT_BIT = 31;
  localparam int STAT_SYNC_LSB = 16;
  // Disabled-level codes
  localparam logic [1:0] DIS_LEVEL_LOW = 2'h0;
  localparam logic [1:0] DIS_LEVEL_HIGH = 2'h1;
  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] FORCE_LO_RESET = 8'h00;
  localparam logic [3:0] FORCE_HI_RESET = 4'h0;
  localparam logic [7:0] ALARM_MSK_RESET = 8'h00;
  localparam logic [3:0] LOCK_MSK_RESET = 4'h0;
endpackage

// File: hdl/odd_drv_ctl.sv
`timescale 1ns/1ps
`default_nettype none
module odd_drv_ctl
  import odd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic out_enable,
  input wire logic power_down,
  input wire logic force_active,
  input wire logic fault,
  input wire logic [1:0] dis_level,
  output logic drv_active,
  output logic drv_hold_high
);
  logic active_next;
  logic hold_next;

  always_comb begin
    // Force keeps the driver up through faults, not through power down
    active_next = out_enable & ~power_down & (~fault | force_active);
    // Reserved codes fall back to low so an idle pin never floats high
    hold_next = (dis_level == DIS_LEVEL_HIGH);
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      drv_active <= 1'b0;
      drv_hold_high <= 1'b0;
    end else begin
      drv_active <= active_next;
      drv_hold_high <= hold_next;
    end
  end
endmodule
`default_nettype wire

// File: verification/odd_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module odd_top_props
  import odd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [odd_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic alarm,
  input wire logic crystal_ref_loss,
  input wire logic [odd_pkg::N_LOOP-1:0] loop_unlocked,
  input wire logic [odd_pkg::N_OUT-1:0] drv_active,
  input wire logic [odd_pkg::N_OUT-1:0] drv_hold_high
);
  logic wr, acc, am, rm, ka, kr, kl;
  logic [1:0] a_s, r_s;
  logic [N_LOOP-1:0] l1, l2, lm;
  logic [N_OUT-1:0] frc, fq;
  logic [IDX_W-1:0] idx;
  assign idx = paddr[11:2];
  assign acc = psel && penable;
  assign wr = acc && pwrite && pstrb[0] && paddr[1:0] == 2'h0;
  // Mirrors the two-flop input sync so kill flags line up with drivers
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      {a_s, r_s, l1, l2, lm, am, rm, frc, fq, ka, kr, kl} <= '0;
    end else begin
      a_s <= {a_s[0], alarm};
      r_s <= {r_s[0], crystal_ref_loss};
      l1 <= loop_unlocked;
      l2 <= l1;
      if (wr && idx == IDX_ALARM_MSK) begin
        {rm, am} <= {pwdata[REF_LOSS_MSK_BIT], pwdata[ALARM_MSK_BIT]};
      end
      if (wr && idx == IDX_LOCK_MSK) lm <= pwdata[3:0];
      if (wr && idx == IDX_FORCE_LO) frc[7:0] <= pwdata[7:0];
      if (wr && idx == IDX_FORCE_HI) frc[11:8] <= pwdata[3:0];
      ka <= a_s[1] && !am;
      kr <= r_s[1] && !rm;
      kl <= |(l2 & ~lm);
      fq <= frc;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  a_err_access: assert property (
    pslverr |-> acc) else $error("error outside access");
  a_unmapped_err: assert property (
    acc && (idx < IDX_CFG_BASE || idx > IDX_LOCK_MSK && idx != IDX_STATUS)
    |-> pslverr) else $error("unmapped not refused");
  a_group_ok: assert property (
    acc && paddr[1:0] == 2'h0 && idx >= IDX_CFG_BASE && idx <= IDX_LOCK_MSK
    |-> !pslverr) else $error("mapped access refused");
  a_drv_cause: assert property (
    $changed(drv_active) |-> $past(wr, 2) || $past(alarm, 3) != $past(alarm, 4)
    || $past(crystal_ref_loss, 3) != $past(crystal_ref_loss, 4)
    || $past(loop_unlocked, 3) != $past(loop_unlocked, 4))
    else $error("driver changed without cause");
  a_alarm_kill: assert property (
    ka |-> (drv_active & ~fq) == '0) else $error("alarm did not disable");
  a_ref_kill: assert property (
    kr |-> (drv_active & ~fq) == '0) else $error("ref loss did not disable");
  a_lock_kill: assert property (
    kl |-> (drv_active & ~fq) == '0) else $error("unlock did not disable");
  a_force_hold: assert property (
    ($past(drv_active) & fq & ~drv_active) != '0 |-> $past(wr, 2))
    else $error("forced driver dropped");
endmodule
bind odd_top odd_top_props u_props (.mclk, .rst_b, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .alarm,
  .crystal_ref_loss, .loop_unlocked, .drv_active, .drv_hold_high);
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import odd_pkg::*;
  logic mclk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'h1;
  logic pready, pslverr, err, alarm = 0, crystal_ref_loss = 0;
  logic [N_LOOP-1:0] loop_unlocked = '0;
  logic [N_OUT-1:0] drv_active, drv_hold_high;
  int err_count = 0, compares = 0;
  always #4 mclk = ~mclk;
  odd_top i_dut (.mclk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .alarm, .crystal_ref_loss,
    .loop_unlocked, .drv_active, .drv_hold_high);
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Leaves one idle cycle so psel is never reassigned in one time step
  task automatic apb(input logic w, input logic [IDX_W-1:0] i,
      input logic [7:0] d);
    logic rdy;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    // Answer taken at the edge that samples pready, before outputs update
    do begin
      @(posedge mclk);
      rdy = pready;
      rd = prdata;
      err = pslverr;
    end while (rdy !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rchk(input logic [IDX_W-1:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    check(rd, {24'h0, e});
  endtask
  // Fault path takes three edges; one more for margin
  task automatic dchk(input logic [N_OUT-1:0] e);
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    check(drv_active, e);
    @(posedge mclk);
  endtask
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    rchk(IDX_FORCE_LO, FORCE_LO_RESET);
    rchk(IDX_FORCE_HI, FORCE_HI_RESET);
    rchk(IDX_ALARM_MSK, ALARM_MSK_RESET);
    rchk(IDX_LOCK_MSK, LOCK_MSK_RESET);
    for (int k = 0; k < N_OUT; k++) begin
      apb(1'b1, IDX_W'(IDX_CFG_BASE + 5 * k), 8'h02);
      apb(1'b1, IDX_W'(IDX_CFG_BASE + 5 * k + 1), k[0] ? 8'h10 : 8'h00);
    end
    rchk(10'h108, 8'h02);
    rchk(10'h109, 8'h10);
    apb(1'b1, IDX_CFG_LAST, 8'h5A);
    rchk(IDX_CFG_LAST, 8'h5A);
    apb(1'b0, 10'h143, 8'h00);
    check(err, 1'b1);
    dchk(12'hFFF);
    alarm <= 1'b1;
    dchk(12'h000);
    check(drv_hold_high, 12'hAAA);
    apb(1'b1, IDX_ALARM_MSK, 8'hFF);
    rchk(IDX_ALARM_MSK, 8'h42);
    dchk(12'hFFF);
    apb(1'b1, IDX_ALARM_MSK, 8'h02);
    apb(1'b1, IDX_FORCE_LO, 8'h81);
    apb(1'b1, IDX_FORCE_HI, 8'h08);
    crystal_ref_loss <= 1'b1;
    dchk(12'h881);
    apb(1'b1, IDX_ALARM_MSK, 8'h40);
    dchk(12'h881);
    apb(1'b1, IDX_ALARM_MSK, 8'h42);
    dchk(12'hFFF);
    for (int i = 0; i < N_LOOP; i++) begin
      loop_unlocked <= N_LOOP'(1 << i);
      apb(1'b1, IDX_LOCK_MSK, 8'h00);
      dchk(12'h881);
      apb(1'b1, IDX_LOCK_MSK, 8'(1 << i));
      dchk(12'hFFF);
    end
    // Status: all drivers up, synced pins {1,1,4'h8}, no unmasked fault
    apb(1'b0, IDX_STATUS, 8'h00);
    check(rd, 32'h0038_0FFF);
    // Power down out0, give it a reserved level code that must hold low
    apb(1'b1, 10'h108, 8'h03);
    apb(1'b1, 10'h109, 8'h30);
    dchk(12'hFFD);
    check(drv_hold_high, 12'hAA8);
    tally_and_finish();
  end
endmodule
`default_nettype wire
